// ===== design/mixer_regs_pkg.sv
// Package: register map, field positions and pipeline constants
package mixer_regs_pkg;

    // ****
    // Register offsets (byte addresses = 4 x index)
    // ****
    localparam logic [3:0] IDX_A_CTRL = 4'h0;
    localparam logic [3:0] IDX_B_CTRL = 4'h1;
    localparam logic [3:0] IDX_OUT_CTRL = 4'h6;
    localparam logic [3:0] IDX_CONV_CTRL = 4'h7;
    localparam logic [3:0] IDX_REV = 4'h8;
    localparam logic [3:0] IDX_PART = 4'h9;
    localparam int ADDR_W = 6;

    // ****
    // Reset values
    // ****
    localparam logic [7:0] A_CTRL_RST = 8'h00;
    localparam logic [7:0] B_CTRL_RST = 8'h00;
    localparam logic [7:0] OUT_CTRL_RST = 8'h00;
    localparam logic [7:0] CONV_CTRL_RST = 8'h00;
    // Identity values are arbitrary
    localparam logic [7:0] REVISION_CODE = 8'h01;
    localparam logic [7:0] PART_TYPE_CODE = 8'h5A;

    // ****
    // A-channel control fields
    // ****
    localparam int A_OVL_BIT = 7;
    localparam int A_DEC_BIT = 6;
    localparam int A_MAT_BIT = 5;
    localparam int A_COLOUR_TABLE_ENABLE_BIT = 4;
    localparam int A_MSB_BIT = 3;
    localparam int A_GAIN_BIT = 2;
    localparam int A_FMT_LO = 0;

    // ****
    // B-channel control fields
    // ****
    localparam int B_SRC_LO = 5;
    localparam int B_MAT_BIT = 4;
    localparam int B_INT_BIT = 3;
    localparam int B_MSB_BIT = 2;
    localparam int B_FMT_LO = 0;
    localparam logic [7:0] B_CTRL_MASK = 8'h7F;

    // ****
    // Output and converter control fields
    // ****
    localparam int O_AUX_VIDEO_LATENCY_SELECT_BIT = 7;
    localparam int O_PASS_BIT = 4;
    localparam int O_PASSCH_BIT = 3;
    localparam int O_PIXEL_OUTPUT_ENABLE_BIT = 2;
    localparam int O_MMSB_BIT = 1;
    localparam int O_MFMT_BIT = 0;
    localparam logic [7:0] OUT_CTRL_MASK = 8'hBF;
    localparam int C_DLY_BIT = 5;
    localparam int C_FMT_BIT = 4;
    localparam int C_MAT_BIT = 0;
    localparam logic [7:0] CONV_CTRL_MASK = 8'h3D;

    // ****
    // Encodings and timing
    // ****
    typedef enum logic [1:0] {
        SRC_MIXER = 2'b00,
        SRC_A = 2'b01,
        SRC_B = 2'b10,
        SRC_RSVD = 2'b11
    } out_source_t;
    localparam logic [1:0] FMT_444 = 2'b00;
    localparam logic [1:0] FMT_422 = 2'b01;
    localparam logic [1:0] FMT_INDEX = 2'b10;
    localparam logic [1:0] FMT_GBR = 2'b11;
    localparam int AUX_LAT_LONG = 14;
    localparam int AUX_LAT_SHORT = 12;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

endpackage : mixer_regs_pkg

// ===== design/mixer_delay_line.sv
// Fixed-length delay line with selectable tap
`timescale 1ns/1ps
`default_nettype none
module mixer_delay_line #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 14,
    parameter int TAP = 12
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Data
    input wire logic [WIDTH-1:0] i_data,
    input wire logic i_short,
    output logic [WIDTH-1:0] o_data
);

    logic [WIDTH-1:0] stage_reg [DEPTH];

    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            for (int i = 0; i < DEPTH; i++)
                stage_reg[i] <= '0;
        end
        else
        begin
            stage_reg[0] <= i_data;
            for (int i = 1; i < DEPTH; i++)
                stage_reg[i] <= stage_reg[i-1];
        end
    end

    assign o_data = i_short ? stage_reg[TAP-1] : stage_reg[DEPTH-1];

endmodule : mixer_delay_line
`default_nettype wire

// ===== design/mixer_chroma_msb.sv
// Chroma sign inversion of a packed 24-bit pixel
`timescale 1ns/1ps
`default_nettype none
module mixer_chroma_msb (
    // Pixel in and out
    input wire logic [23:0] i_pixel,
    input wire logic i_invert,
    output logic [23:0] o_pixel
);

    // Bits 15 and 7 carry the chroma sign
    assign o_pixel = i_invert ? (i_pixel ^ 24'h008080) : i_pixel;

endmodule : mixer_chroma_msb
`default_nettype wire

// ===== design/mixer_path_ctrl.sv
// Video mixer path control registers and pixel path steering
`timescale 1ns/1ps
`default_nettype none
module mixer_path_ctrl
    import mixer_regs_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] I_AWADDR,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    input wire logic I_WVALID,
    output logic O_WREADY,
    // AXI4-Lite write response
    output logic [1:0] O_BRESP,
    output logic O_BVALID,
    input wire logic I_BREADY,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] I_ARADDR,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_RVALID,
    input wire logic I_RREADY,
    // Pixel inputs
    input wire logic [23:0] I_A_PIXEL_INPUT,
    input wire logic [23:0] I_B_PIXEL_INPUT,
    input wire logic [23:0] I_MIXER_RESULT,
    input wire logic [3:0] I_OVERLAY_INDEX_INPUT,
    input wire logic I_PASS_ENABLE_INPUT_N,
    input wire logic I_AUX_VIDEO_CONTROL,
    // Pixel output, three-state as two signals, and aux video output
    output logic [23:0] O_MIXED_PIXEL_OUTPUT,
    output logic O_MIXED_PIXEL_OE_N,
    output logic O_AUX_VIDEO_OUTPUT,
    // Steering to A path
    output logic O_OVERLAY_PALETTE_ENABLE,
    output logic O_A_DECIMATE_ENABLE,
    output logic O_A_TO_LUMA_CHROMA_CONVERT,
    output logic O_COLOUR_TABLE_ENABLE,
    output logic O_ALPHA_GAIN_8BIT,
    output logic [1:0] O_A_INPUT_FORMAT,
    output logic [3:0] O_OVERLAY_INDEX,
    output logic [23:0] O_A_PIXEL,
    // Steering to B path
    output logic O_B_TO_RGB_CONVERT,
    output logic O_B_INTERPOLATE_ENABLE,
    output logic [1:0] O_B_INPUT_FORMAT,
    output logic [23:0] O_B_PIXEL,
    // Steering to converters
    output logic O_CONVERTER_SYNC_BLANK_DELAY,
    output logic O_CONVERTER_CHROMA_OFFSET_BINARY,
    output logic O_CONVERTER_COLOUR_CONVERT
);

    // ************************************************
    // Register file
    // ************************************************
    logic [7:0] a_ctrl_reg;
    logic [7:0] b_ctrl_reg;
    logic [7:0] out_ctrl_reg;
    logic [7:0] conv_ctrl_reg;

    // ************************************************
    // AXI4-Lite write channel
    // ************************************************
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic aw_take;
    logic w_take;
    logic do_write;
    logic [3:0] w_idx;
    logic w_hit;

    assign aw_take = I_AWVALID && O_AWREADY;
    assign w_take = I_WVALID && O_WREADY;
    assign do_write = aw_held_reg && w_held_reg && !O_BVALID;
    assign w_idx = awaddr_reg[5:2];
    assign w_hit = (w_idx == IDX_A_CTRL) || (w_idx == IDX_B_CTRL)
        || (w_idx == IDX_OUT_CTRL) || (w_idx == IDX_CONV_CTRL)
        || (w_idx == IDX_REV) || (w_idx == IDX_PART);

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg <= '0;
            O_AWREADY <= 1'b0;
        end
        else
        begin
            O_AWREADY <= !aw_held_reg && !aw_take && !O_BVALID;
            if (aw_take)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= I_AWADDR;
            end
            else if (do_write)
                aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            w_held_reg <= 1'b0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            O_WREADY <= 1'b0;
        end
        else
        begin
            O_WREADY <= !w_held_reg && !w_take && !O_BVALID;
            if (w_take)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= I_WDATA[7:0];
                wstrb0_reg <= I_WSTRB[0];
            end
            else if (do_write)
                w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            O_BVALID <= 1'b0;
            O_BRESP <= AXI_OKAY;
        end
        else if (do_write)
        begin
            O_BVALID <= 1'b1;
            O_BRESP <= w_hit ? AXI_OKAY : AXI_SLVERR;
        end
        else if (O_BVALID && I_BREADY)
            O_BVALID <= 1'b0;
    end

    // Writable registers; byte lane 0 only, reserved bits read zero
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            a_ctrl_reg <= A_CTRL_RST;
            b_ctrl_reg <= B_CTRL_RST;
            out_ctrl_reg <= OUT_CTRL_RST;
            conv_ctrl_reg <= CONV_CTRL_RST;
        end
        else if (do_write && wstrb0_reg)
        begin
            unique case (w_idx)
                IDX_A_CTRL: a_ctrl_reg <= wdata_reg;
                IDX_B_CTRL: b_ctrl_reg <= wdata_reg & B_CTRL_MASK;
                IDX_OUT_CTRL: out_ctrl_reg <= wdata_reg & OUT_CTRL_MASK;
                IDX_CONV_CTRL: conv_ctrl_reg <= wdata_reg & CONV_CTRL_MASK;
                default: ;
            endcase
        end
    end

    // ************************************************
    // AXI4-Lite read channel
    // ************************************************
    logic [3:0] r_idx;
    logic [7:0] r_byte;
    logic r_hit;

    assign r_idx = I_ARADDR[5:2];

    always_comb
    begin
        r_hit = 1'b1;
        unique case (r_idx)
            IDX_A_CTRL: r_byte = a_ctrl_reg;
            IDX_B_CTRL: r_byte = b_ctrl_reg;
            IDX_OUT_CTRL: r_byte = out_ctrl_reg;
            IDX_CONV_CTRL: r_byte = conv_ctrl_reg;
            IDX_REV: r_byte = REVISION_CODE;
            IDX_PART: r_byte = PART_TYPE_CODE;
            default:
            begin
                r_byte = 8'h00;
                r_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h00000000;
            O_RRESP <= AXI_OKAY;
        end
        else
        begin
            O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
            if (I_ARVALID && O_ARREADY)
            begin
                O_RVALID <= 1'b1;
                O_RDATA <= {24'h000000, r_byte};
                O_RRESP <= r_hit ? AXI_OKAY : AXI_SLVERR;
            end
            else if (O_RVALID && I_RREADY)
                O_RVALID <= 1'b0;
        end
    end

    // ************************************************
    // Input pixel stage
    // ************************************************
    logic [23:0] a_sign_fixed;
    logic [23:0] b_sign_fixed;

    mixer_chroma_msb u_a_msb (
        .i_pixel(I_A_PIXEL_INPUT),
        .i_invert(a_ctrl_reg[A_MSB_BIT]),
        .o_pixel(a_sign_fixed)
    );

    mixer_chroma_msb u_b_msb (
        .i_pixel(I_B_PIXEL_INPUT),
        .i_invert(b_ctrl_reg[B_MSB_BIT]),
        .o_pixel(b_sign_fixed)
    );

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            O_A_PIXEL <= 24'h000000;
            O_B_PIXEL <= 24'h000000;
            O_OVERLAY_INDEX <= 4'h0;
        end
        else
        begin
            O_A_PIXEL <= a_sign_fixed;
            O_B_PIXEL <= b_sign_fixed;
            // Index held at zero while palette disabled
            O_OVERLAY_INDEX <= a_ctrl_reg[A_OVL_BIT]
                ? I_OVERLAY_INDEX_INPUT : 4'h0;
        end
    end

    // ************************************************
    // Path steering from registers
    // ************************************************
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            O_OVERLAY_PALETTE_ENABLE <= 1'b0;
            O_A_DECIMATE_ENABLE <= 1'b0;
            O_A_TO_LUMA_CHROMA_CONVERT <= 1'b0;
            O_COLOUR_TABLE_ENABLE <= 1'b0;
            O_ALPHA_GAIN_8BIT <= 1'b0;
            O_A_INPUT_FORMAT <= FMT_444;
            O_B_TO_RGB_CONVERT <= 1'b0;
            O_B_INTERPOLATE_ENABLE <= 1'b0;
            O_B_INPUT_FORMAT <= FMT_444;
            O_CONVERTER_SYNC_BLANK_DELAY <= 1'b0;
            O_CONVERTER_CHROMA_OFFSET_BINARY <= 1'b0;
            O_CONVERTER_COLOUR_CONVERT <= 1'b0;
        end
        else
        begin
            O_OVERLAY_PALETTE_ENABLE <= a_ctrl_reg[A_OVL_BIT];
            O_A_DECIMATE_ENABLE <= a_ctrl_reg[A_DEC_BIT];
            O_A_TO_LUMA_CHROMA_CONVERT <= a_ctrl_reg[A_MAT_BIT];
            O_COLOUR_TABLE_ENABLE <= a_ctrl_reg[A_COLOUR_TABLE_ENABLE_BIT];
            O_ALPHA_GAIN_8BIT <= a_ctrl_reg[A_GAIN_BIT];
            O_A_INPUT_FORMAT <= a_ctrl_reg[A_FMT_LO +: 2];
            O_B_TO_RGB_CONVERT <= b_ctrl_reg[B_MAT_BIT];
            O_B_INTERPOLATE_ENABLE <= b_ctrl_reg[B_INT_BIT];
            O_B_INPUT_FORMAT <= b_ctrl_reg[B_FMT_LO +: 2];
            O_CONVERTER_SYNC_BLANK_DELAY <= conv_ctrl_reg[C_DLY_BIT];
            O_CONVERTER_CHROMA_OFFSET_BINARY <= conv_ctrl_reg[C_FMT_BIT];
            O_CONVERTER_COLOUR_CONVERT <= conv_ctrl_reg[C_MAT_BIT];
        end
    end

    // ************************************************
    // Digital output selection
    // ************************************************
    logic [23:0] sel_pixel;
    logic [23:0] fmt_pixel;
    logic [23:0] msb_pixel;
    logic phase_reg;
    out_source_t src;

    assign src = out_source_t'(b_ctrl_reg[B_SRC_LO +: 2]);

    always_comb
    begin
        if (out_ctrl_reg[O_PASS_BIT] && !I_PASS_ENABLE_INPUT_N)
            sel_pixel = out_ctrl_reg[O_PASSCH_BIT]
                ? I_B_PIXEL_INPUT : I_A_PIXEL_INPUT;
        else
        begin
            unique case (src)
                SRC_MIXER: sel_pixel = I_MIXER_RESULT;
                SRC_A: sel_pixel = a_sign_fixed;
                SRC_B: sel_pixel = b_sign_fixed;
                SRC_RSVD: sel_pixel = I_MIXER_RESULT;
            endcase
        end
    end

    // 4:2:2 mux: luma on bits 23-16, Cb and Cr alternate on 15-8
    always_comb
    begin
        fmt_pixel = sel_pixel;
        if (out_ctrl_reg[O_MFMT_BIT])
            fmt_pixel = {sel_pixel[23:16],
                phase_reg ? sel_pixel[7:0] : sel_pixel[15:8],
                8'h00};
    end

    assign msb_pixel = out_ctrl_reg[O_MMSB_BIT]
        ? (fmt_pixel ^ 24'h008080) : fmt_pixel;

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            phase_reg <= 1'b0;
        else
            phase_reg <= out_ctrl_reg[O_MFMT_BIT] ? !phase_reg : 1'b0;
    end

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
        begin
            O_MIXED_PIXEL_OUTPUT <= 24'h000000;
            O_MIXED_PIXEL_OE_N <= 1'b1;
        end
        else
        begin
            // Pass mode output is not sign-adjusted
            O_MIXED_PIXEL_OUTPUT <= (out_ctrl_reg[O_PASS_BIT]
                && !I_PASS_ENABLE_INPUT_N) ? sel_pixel : msb_pixel;
            O_MIXED_PIXEL_OE_N <= !out_ctrl_reg[O_PIXEL_OUTPUT_ENABLE_BIT];
        end
    end

    // ************************************************
    // Auxiliary video delay
    // ************************************************
    logic aux_delayed;

    // Tap counts the output flop, hence one less
    mixer_delay_line #(
        .WIDTH(1),
        .DEPTH(AUX_LAT_LONG - 1),
        .TAP(AUX_LAT_SHORT - 1)
    ) u_aux_delay (
        .i_clk(I_CLK),
        .i_rstn(I_RSTN),
        .i_data(I_AUX_VIDEO_CONTROL),
        .i_short(out_ctrl_reg[O_AUX_VIDEO_LATENCY_SELECT_BIT]),
        .o_data(aux_delayed)
    );

    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            O_AUX_VIDEO_OUTPUT <= 1'b0;
        else
            O_AUX_VIDEO_OUTPUT <= aux_delayed;
    end

endmodule : mixer_path_ctrl
`default_nettype wire

// ===== test/mixer_path_asserts.sv
// Checker for the mixer path control register bank
`timescale 1ns/1ps
`default_nettype none
module mixer_path_asserts (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RSTN,
    // Bus handshakes
    input wire logic I_AWVALID,
    input wire logic O_AWREADY,
    input wire logic I_WVALID,
    input wire logic O_WREADY,
    input wire logic [1:0] O_BRESP,
    input wire logic O_BVALID,
    input wire logic I_BREADY,
    input wire logic I_ARVALID,
    input wire logic O_ARREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic O_RVALID,
    input wire logic I_RREADY,
    // Pixel side
    input wire logic [23:0] I_B_PIXEL_INPUT,
    input wire logic [23:0] O_B_PIXEL,
    input wire logic [3:0] I_OVERLAY_INDEX_INPUT,
    input wire logic [3:0] O_OVERLAY_INDEX,
    input wire logic O_OVERLAY_PALETTE_ENABLE,
    input wire logic I_AUX_VIDEO_CONTROL,
    input wire logic O_AUX_VIDEO_OUTPUT,
    input wire logic O_MIXED_PIXEL_OE_N
);
    // ****
    // Cycles since reset, saturating
    // ****
    logic [4:0] run_cnt;
    always_ff @(posedge I_CLK or negedge I_RSTN)
    begin
        if (!I_RSTN)
            run_cnt <= 5'h00;
        else if (run_cnt != 5'h14)
            run_cnt <= run_cnt + 5'h01;
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    // ****
    // Properties
    // ****
    bresp_hold_a:
        assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped early");
    rdata_hold_a:
        assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped early");
    write_answer_a:
        assert property (I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
            |-> ##[1:2] O_BVALID) else $error("no write response");
    read_answer_a:
        assert property (I_ARVALID && O_ARREADY |-> ##[1:2] O_RVALID)
        else $error("no read response");
    rsvd_zero_a:
        assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
        else $error("upper read data not zero");
    ovl_index_a:
        assert property (O_OVERLAY_PALETTE_ENABLE
            && $past(O_OVERLAY_PALETTE_ENABLE)
            |-> O_OVERLAY_INDEX == $past(I_OVERLAY_INDEX_INPUT))
        else $error("overlay index not forwarded");
    ovl_off_a:
        assert property (!O_OVERLAY_PALETTE_ENABLE
            && !$past(O_OVERLAY_PALETTE_ENABLE) |-> O_OVERLAY_INDEX == 4'h0)
        else $error("overlay index active while disabled");
    b_sign_a:
        assert property (run_cnt > 5'h01
            |-> (O_B_PIXEL ^ $past(I_B_PIXEL_INPUT)) inside
            {24'h000000, 24'h008080}) else $error("B pixel corrupted");
    aux_delay_a:
        assert property (run_cnt > 5'h10
            |-> O_AUX_VIDEO_OUTPUT == $past(I_AUX_VIDEO_CONTROL, 14)
            || O_AUX_VIDEO_OUTPUT == $past(I_AUX_VIDEO_CONTROL, 12))
        else $error("aux video delay wrong");
    oe_cause_a:
        assert property ($changed(O_MIXED_PIXEL_OE_N)
            |-> $past(O_BVALID) || $past(O_BVALID, 2))
        else $error("output enable moved without a write");
    cover property (O_BVALID && I_BREADY);
    cover property (O_RVALID && I_RREADY);
    cover property (!O_MIXED_PIXEL_OE_N && O_OVERLAY_PALETTE_ENABLE);
endmodule : mixer_path_asserts
bind mixer_path_ctrl mixer_path_asserts i_chk (.*);
`default_nettype wire

// ===== test/video_source_model.sv
// Upstream video source: pixel, overlay and aux streams
`timescale 1ns/1ps
`default_nettype none
module video_source_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Streams
    output logic [23:0] o_a_pixel,
    output logic [23:0] o_b_pixel,
    output logic [23:0] o_mix_pixel,
    output logic [3:0] o_overlay_index,
    output logic o_aux
);
    logic [7:0] cnt_reg;
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= cnt_reg + 8'h01;
    end
    // Pixel and overlay streams change each cycle; aux does not always change
    assign o_a_pixel = {cnt_reg, ~cnt_reg, cnt_reg ^ 8'hA5};
    assign o_b_pixel = {cnt_reg ^ 8'h3C, cnt_reg, ~cnt_reg};
    assign o_mix_pixel = {~cnt_reg, cnt_reg ^ 8'h5A, cnt_reg};
    assign o_overlay_index = cnt_reg[3:0] ^ 4'h9;
    assign o_aux = cnt_reg[0] ^ cnt_reg[3] ^ cnt_reg[5];
endmodule : video_source_model
`default_nettype wire

// ===== test/tb_video_mixer_path_control_regs.sv
// Testbench for the video mixer path control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    err_count++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_video_mixer_path_control_regs
    import mixer_regs_pkg::*;
;
    logic clk, rstn, aw_valid, w_valid, b_ready, ar_valid, r_ready, pass_n;
    logic [5:0] aw_addr, ar_addr;
    logic [31:0] w_data, r_data;
    logic [3:0] w_strb, ovl_in, ovl_idx;
    logic aw_ready, w_ready, b_valid, ar_ready, r_valid, oe_n, aux_out;
    logic ovl_en, dec, a_mat, colour_table_enable, gain8, b_mat, b_int, c_dly, c_fmt, c_mat;
    logic aux_in;
    logic [1:0] b_resp, r_resp, a_fmt, b_fmt;
    logic [23:0] a_in, b_in, mix_in, mix_out, a_pix, b_pix, sa, sb, sm;
    logic [15:0] hist;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    mixer_path_ctrl i_dut (.I_CLK(clk), .I_RSTN(rstn), .I_AWADDR(aw_addr),
        .I_AWVALID(aw_valid), .O_AWREADY(aw_ready), .I_WDATA(w_data),
        .I_WSTRB(w_strb), .I_WVALID(w_valid), .O_WREADY(w_ready),
        .O_BRESP(b_resp), .O_BVALID(b_valid), .I_BREADY(b_ready),
        .I_ARADDR(ar_addr), .I_ARVALID(ar_valid), .O_ARREADY(ar_ready),
        .O_RDATA(r_data), .O_RRESP(r_resp), .O_RVALID(r_valid),
        .I_RREADY(r_ready), .I_A_PIXEL_INPUT(a_in), .I_B_PIXEL_INPUT(b_in),
        .I_MIXER_RESULT(mix_in), .I_OVERLAY_INDEX_INPUT(ovl_in),
        .I_PASS_ENABLE_INPUT_N(pass_n), .I_AUX_VIDEO_CONTROL(aux_in),
        .O_MIXED_PIXEL_OUTPUT(mix_out), .O_MIXED_PIXEL_OE_N(oe_n),
        .O_AUX_VIDEO_OUTPUT(aux_out), .O_OVERLAY_PALETTE_ENABLE(ovl_en),
        .O_A_DECIMATE_ENABLE(dec), .O_A_TO_LUMA_CHROMA_CONVERT(a_mat),
        .O_COLOUR_TABLE_ENABLE(colour_table_enable), .O_ALPHA_GAIN_8BIT(gain8),
        .O_A_INPUT_FORMAT(a_fmt), .O_OVERLAY_INDEX(ovl_idx),
        .O_A_PIXEL(a_pix), .O_B_TO_RGB_CONVERT(b_mat),
        .O_B_INTERPOLATE_ENABLE(b_int), .O_B_INPUT_FORMAT(b_fmt),
        .O_B_PIXEL(b_pix), .O_CONVERTER_SYNC_BLANK_DELAY(c_dly),
        .O_CONVERTER_CHROMA_OFFSET_BINARY(c_fmt),
        .O_CONVERTER_COLOUR_CONVERT(c_mat));
    video_source_model i_src (.i_clk(clk), .i_rstn(rstn), .o_a_pixel(a_in),
        .o_b_pixel(b_in), .o_mix_pixel(mix_in), .o_overlay_index(ovl_in),
        .o_aux(aux_in));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        hist <= {hist[14:0], aux_in};
        cycles++;
        if (cycles == 4000)
        begin
            err_count++;
            final_report();
        end
    end
    task final_report;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // ****
    // Bus cycles; r_ready is raised late to stall read responses, b_ready rises with b_valid
    // ****
    task automatic axi_wr(input logic [5:0] a, input logic [7:0] d,
        input logic [1:0] er = AXI_OKAY);
        logic aw_left, w_left;
        aw_left = 1'b1;
        w_left = 1'b1;
        @(posedge clk);
        aw_addr <= a;
        w_data <= {24'h000000, d};
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        while (aw_left || w_left)
        begin
            @(posedge clk);
            if (aw_left && aw_ready)
                aw_valid <= 1'b0;
            if (w_left && w_ready)
                w_valid <= 1'b0;
            aw_left = aw_left && !aw_ready;
            w_left = w_left && !w_ready;
        end
        @(posedge clk);
        b_ready <= 1'b1;
        do @(posedge clk); while (b_valid !== 1'b1);
        b_ready <= 1'b0;
        `CHK("bresp", er, b_resp)
    endtask : axi_wr
    task automatic axi_rd(input logic [5:0] a, input logic [7:0] ed,
        input logic [1:0] er = AXI_OKAY);
        @(posedge clk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        do @(posedge clk); while (ar_ready !== 1'b1);
        ar_valid <= 1'b0;
        @(posedge clk);
        r_ready <= 1'b1;
        do @(posedge clk); while (r_valid !== 1'b1);
        r_ready <= 1'b0;
        `CHK("rresp", er, r_resp)
        `CHK("rdata", {24'h000000, ed}, r_data)
    endtask : axi_rd
    task automatic grab;
        @(posedge clk);
        sa = a_in;
        sb = b_in;
        sm = mix_in;
        @(negedge clk);
    endtask : grab
    // ****
    // Scenarios
    // ****
    task automatic t_regs;
        logic [5:0] ad [6] = '{6'h00, 6'h04, 6'h18, 6'h1C, 6'h20, 6'h24};
        logic [7:0] wv [6] = '{8'hFF, 8'hFF, 8'h9F, 8'h31, 8'hFF, 8'hFF};
        logic [7:0] ev [6] = '{8'hFF, 8'h7F, 8'h9F, 8'h31, REVISION_CODE,
            PART_TYPE_CODE};
        for (int i = 0; i < 6; i++)
        begin
            axi_rd(ad[i], (i < 4) ? 8'h00 : ev[i]);
            axi_wr(ad[i], wv[i]);
            axi_rd(ad[i], ev[i]);
        end
        axi_wr(6'h08, 8'h55, AXI_SLVERR);
        axi_rd(6'h08, 8'h00, AXI_SLVERR);
        w_strb <= 4'hE;
        axi_wr(6'h00, 8'h00);
        w_strb <= 4'hF;
        axi_rd(6'h00, 8'hFF);
        $display("test regs done");
    endtask : t_regs
    task automatic t_steer;
        logic [7:0] v, bv, cv;
        for (int k = 0; k < 4; k++)
        begin
            v = {4{k[1:0]}};
            cv = v & 8'h31;
            axi_wr(6'h00, v);
            axi_wr(6'h1C, cv);
            if (k != 2)
                bv = v & 8'h1F;
            axi_wr(6'h04, bv);
            repeat (2) @(posedge clk);
            `CHK("ovl_en", v[7], ovl_en)
            `CHK("dec", v[6], dec)
            `CHK("a_mat", v[5], a_mat)
            `CHK("colour_table_enable", v[4], colour_table_enable)
            `CHK("gain8", v[2], gain8)
            `CHK("a_fmt", v[1:0], a_fmt)
            `CHK("b_mat", bv[4], b_mat)
            `CHK("b_int", bv[3], b_int)
            `CHK("b_fmt", bv[1:0], b_fmt)
            `CHK("c_dly", cv[5], c_dly)
            `CHK("c_fmt", cv[4], c_fmt)
            `CHK("c_mat", cv[0], c_mat)
        end
        $display("test steer done");
    endtask : t_steer
    task automatic t_pixels;
        axi_wr(6'h00, 8'h08);
        axi_wr(6'h04, 8'h04);
        axi_wr(6'h18, 8'h04);
        grab();
        `CHK("a_pix", sa ^ 24'h008080, a_pix)
        `CHK("b_pix", sb ^ 24'h008080, b_pix)
        `CHK("oe_on", 1'b0, oe_n)
        `CHK("src_mix", sm, mix_out)
        axi_wr(6'h04, 8'h20);
        grab();
        `CHK("src_a", sa ^ 24'h008080, mix_out)
        axi_wr(6'h04, 8'h44);
        grab();
        `CHK("src_b", sb ^ 24'h008080, mix_out)
        pass_n <= 1'b0;
        axi_wr(6'h18, 8'h14);
        grab();
        `CHK("pass_a", sa, mix_out)
        axi_wr(6'h18, 8'h1C);
        grab();
        `CHK("pass_b", sb, mix_out)
        pass_n <= 1'b1;
        repeat (2) grab();
        `CHK("pass_off", sb ^ 24'h008080, mix_out)
        axi_wr(6'h18, 8'h05);
        grab();
        `CHK("fmt_y", sb[23:16], mix_out[23:16])
        `CHK("fmt_low", 8'h00, mix_out[7:0])
        axi_wr(6'h18, 8'h06);
        grab();
        `CHK("out_msb", sb, mix_out)
        axi_wr(6'h18, 8'h00);
        repeat (2) @(posedge clk);
        `CHK("oe_off", 1'b1, oe_n)
        $display("test pixels done");
    endtask : t_pixels
    task automatic t_aux;
        for (int m = 0; m < 2; m++)
        begin
            axi_wr(6'h18, m[0] ? 8'h80 : 8'h00);
            repeat (16) @(posedge clk);
            for (int j = 0; j < 8; j++)
            begin
                @(negedge clk);
                `CHK("aux", m[0] ? hist[11] : hist[13], aux_out)
            end
        end
        $display("test aux done");
    endtask : t_aux
    initial
    begin
        {rstn, aw_valid, w_valid, b_ready, ar_valid, r_ready} = 6'h00;
        {aw_addr, ar_addr, w_data} = 44'h0;
        w_strb = 4'hF;
        pass_n = 1'b1;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_steer();
        t_pixels();
        t_aux();
        final_report();
    end
endmodule : tb_video_mixer_path_control_regs
`default_nettype wire
